// file: dv/ssw_far_model.sv
// Far-side model: port A and port B serial devices and the select terminal wiring
`timescale 1ns/10ps
module ssw_far_model
(
	input wire logic portSelectOut, // Status terminal value from the switch
	input wire logic portSelectOe, // Status terminal enable from the switch
	input wire logic wantPortB, // Outside party pulls the terminal high for port B
	output logic portSelectIn, // Resolved terminal level
	output logic portARxData, // Line from the port A device
	output logic portBRxData // Line from the port B device
);
	// The switch wins the terminal while it drives; otherwise the outside pull sets it
	assign portSelectIn = portSelectOe ? portSelectOut : wantPortB;
	// Opposite fixed levels so the bench can tell which port reaches the logger
	assign portARxData = 1'b0;
	assign portBRxData = 1'b1;
endmodule

// file: dv/tb_top.sv
// Bench: register tasks over AXI4-Lite and pin scenarios for the serial port switch
`timescale 1ns/10ps
module tb_top;
	import ssw_pkg::*;
	logic clock = 0;
	logic reset_n = 0;
	logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic wake = 0, syncReq = 0, manual = 0, wantB = 0, logTx = 1;
	logic selIn, selOut, selOe, logRx, aTx, aRx, bTx, bRx, supDte, supDce;
	int failures = 0;
	int checks = 0;
	int cycles = 0;

	// Free-running clock at 100 MHz
	always #5 clock = ~clock;

	ssw_serial_port_switch dut_u (.clock(clock), .reset_n(reset_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.logger_wake_request(wake), .sync_or_print_request(syncReq), .manualMode(manual),
		.portSelectIn(selIn), .portSelectOut(selOut), .portSelectOe(selOe),
		.loggerTxData(logTx), .loggerRxData(logRx), .portATxData(aTx), .portARxData(aRx),
		.portBTxData(bTx), .portBRxData(bRx), .supplyDtePair(supDte), .supplyDcePair(supDce));

	ssw_far_model far_u (.portSelectOut(selOut), .portSelectOe(selOe), .wantPortB(wantB),
		.portSelectIn(selIn), .portARxData(aRx), .portBRxData(bRx));

	task automatic test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Ceiling well above the few hundred cycles the tests need
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			test_done();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clock);
	endtask

	// Ready is a flop output, so its level before the edge decides the transfer
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		bit pa, pw, ta, tw;
		pa = 1;
		pw = 1;
		@(posedge clock);
		awaddr <= a;
		awvalid <= 1;
		wdata <= d;
		wstrb <= 4'hf;
		wvalid <= 1;
		bready <= 1;
		while (pa || pw)
		begin
			@(negedge clock);
			ta = pa && awready === 1'b1;
			tw = pw && wready === 1'b1;
			@(posedge clock);
			if (ta)
			begin
				awvalid <= 0;
				pa = 0;
			end
			if (tw)
			begin
				wvalid <= 0;
				pw = 0;
			end
		end
		do @(negedge clock); while (bvalid !== 1'b1);
		check(bresp, er, "write response");
		@(posedge clock);
		bready <= 0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(negedge clock); while (arready !== 1'b1);
		@(posedge clock);
		arvalid <= 0;
		do @(negedge clock); while (rvalid !== 1'b1);
		check(rdata, ed, "read data");
		check(rresp, er, "read response");
		@(posedge clock);
		rready <= 0;
	endtask

	task automatic straps(input logic [31:0] v);
		wr(SSW_ADDR_STRAP, v, SSW_RESP_OKAY);
	endtask

	// Wake pulse; the selection settles a few edges after the fall
	task automatic wakePulse();
		@(posedge clock);
		wake <= 1;
		waitc(6);
		wake <= 0;
		waitc(8);
	endtask

	// Supply table: straps, wake, sync, expected DTE pair, expected DCE pair
	logic [8:0] supStrap [8] = '{9'h110, 9'h010, 9'h090, 9'h010, 9'h010, 9'h050, 9'h030, 9'h000};
	logic [3:0] supCase [8] = '{4'b1000, 4'b1001, 4'b1010, 4'b0000, 4'b0100, 4'b0101,
		4'b0001, 4'b1000};

	initial
	begin
		waitc(16);
		reset_n <= 1;
		// Register map, access kinds and refusals
		rd(SSW_ADDR_STRAP, 32'h0000_0100, SSW_RESP_OKAY);
		rd(SSW_ADDR_IDENT, SSW_IDENT_VALUE, SSW_RESP_OKAY);
		rd(4'hc, 32'h0, SSW_RESP_SLVERR);
		wr(4'hc, 32'hffff_ffff, SSW_RESP_SLVERR);
		wr(SSW_ADDR_IDENT, 32'h0, SSW_RESP_OKAY);
		rd(SSW_ADDR_IDENT, SSW_IDENT_VALUE, SSW_RESP_OKAY);
		straps(32'hffff_ffff);
		rd(SSW_ADDR_STRAP, 32'h0000_01ff, SSW_RESP_OKAY);
		straps(32'h100);
		$display("test registers done");
		// Port A after reset carries logger data both ways
		logTx <= 0;
		waitc(6);
		check(aTx, 0, "port A tx");
		check(bTx, 1, "port B idle");
		check(logRx, 0, "logger rx from A");
		$display("test reset port done");
		// Manual selection of port B, status strap fitted but terminal left as input
		straps(32'h101);
		manual <= 1;
		wantB <= 1;
		waitc(8);
		check(bTx, 0, "port B tx");
		check(aTx, 1, "port A idle");
		check(logRx, 1, "logger rx from B");
		check(selOe, 0, "terminal undriven in manual");
		rd(SSW_ADDR_STATUS, 32'h9, SSW_RESP_OKAY);
		manual <= 0;
		wantB <= 0;
		waitc(8);
		check({selOe, selOut}, 2'b11, "status shows B");
		straps(32'h100);
		waitc(4);
		check(selOe, 0, "terminal undriven without strap");
		$display("test manual done");
		// Wake falls with and without the default-port strap
		straps(32'h101);
		wakePulse();
		check({selOe, selOut}, 2'b11, "last port kept");
		straps(32'h103);
		wakePulse();
		check({selOe, selOut}, 2'b10, "default A");
		check(aTx, 0, "port A tx after default");
		straps(32'h107);
		wakePulse();
		check({selOe, selOut}, 2'b11, "default B");
		check(bTx, 0, "port B tx after default");
		$display("test wake selection done");
		// Sync-block strap on port A
		straps(32'h103);
		wakePulse();
		straps(32'h10b);
		syncReq <= 1;
		waitc(6);
		check(aTx, 1, "port A blocked");
		syncReq <= 0;
		waitc(6);
		check(aTx, 0, "port A unblocked");
		straps(32'h103);
		syncReq <= 1;
		waitc(6);
		check(aTx, 0, "port A passes sync data");
		syncReq <= 0;
		$display("test sync block done");
		// Handshake supply cases
		for (int i = 0; i < 8; i++)
		begin
			straps({23'h0, supStrap[i]});
			wake <= supCase[i][3];
			syncReq <= supCase[i][2];
			waitc(6);
			check({supDte, supDce}, supCase[i][1:0], "supply pairs");
		end
		$display("test supply done");
		test_done();
	end
endmodule

// file: rtl/ssw_pkg.sv
// Package of register map, field positions and reset values for the serial port switch
package ssw_pkg;

	// AXI4-Lite register byte addresses
	localparam logic [3:0] SSW_ADDR_STRAP = 4'h0;
	localparam logic [3:0] SSW_ADDR_STATUS = 4'h4;
	localparam logic [3:0] SSW_ADDR_IDENT = 4'h8;

	// Strap register field positions
	localparam int SSW_STRAP_STATUS_OUT = 0;
	localparam int SSW_STRAP_DEFAULT_PORT = 1;
	localparam int SSW_STRAP_DEFAULT_CHOICE = 2;
	localparam int SSW_STRAP_SYNC_BLOCK = 3;
	localparam int SSW_STRAP_HS_SUPPLY = 4;
	localparam int SSW_STRAP_PERM_SUPPLY = 5;
	localparam int SSW_STRAP_EXT_SUPPLY = 6;
	localparam int SSW_STRAP_ROLE_DTE = 7;
	localparam int SSW_STRAP_ISOLATED = 8;
	localparam int SSW_STRAP_WIDTH = 9;

	// Reset value: every strap but the isolated one absent, role DCE, isolated mode
	localparam logic [8:0] SSW_STRAP_RESET = 9'h100;

	// Status register field positions
	localparam int SSW_STAT_PORT_B = 0;
	localparam int SSW_STAT_WAKE = 1;
	localparam int SSW_STAT_SYNC_REQ = 2;
	localparam int SSW_STAT_MANUAL = 3;
	localparam int SSW_STAT_SUPPLY = 4;
	localparam int SSW_STAT_WIDTH = 5;

	// Identification word, value arbitrary
	localparam logic [31:0] SSW_IDENT_VALUE = 32'h0000_5a01;

	// AXI response codes
	localparam logic [1:0] SSW_RESP_OKAY = 2'h0;
	localparam logic [1:0] SSW_RESP_SLVERR = 2'h2;

	// Idle (mark) level of an asynchronous serial line
	localparam logic SSW_LINE_IDLE = 1'b1;

	// Which communication port is joined to the logger
	typedef enum logic {SSW_SEL_A, SSW_SEL_B} ssw_port_e;

endpackage

// file: rtl/ssw_serial_port_switch.sv
// Strap-configured two-port serial switch with AXI4-Lite strap and status registers
`timescale 1ns/10ps
module ssw_serial_port_switch
	import ssw_pkg::*;
(
	input wire logic clock, // 100 MHz clock
	input wire logic reset_n, // Async reset, active low
	input wire logic [3:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [3:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic logger_wake_request, // Wake request pin from logger
	input wire logic sync_or_print_request, // Sync/print request pin from logger
	input wire logic manualMode, // Manual mode terminal, high = manual
	input wire logic portSelectIn, // Port select terminal, input side
	output logic portSelectOut, // Port select terminal, output side
	output logic portSelectOe, // Port select terminal, output enable
	input wire logic loggerTxData, // Serial data from logger
	output logic loggerRxData, // Serial data to logger
	output logic portATxData, // Serial data to port A
	input wire logic portARxData, // Serial data from port A
	output logic portBTxData, // Serial data to port B
	input wire logic portBRxData, // Serial data from port B
	output logic supplyDtePair, // Supply on DTE-role handshake pair
	output logic supplyDcePair // Supply on DCE-role handshake pair
);

	// Pin synchronisers; first stages read only by second stages
	logic wakeMeta_reg, wakeSync_reg, wakePrev_reg;
	logic syncMeta_reg, syncSync_reg;
	logic manualMeta_reg, manualSync_reg;
	logic selMeta_reg, selSync_reg;
	logic txMeta_reg, txSync_reg;
	logic rxAMeta_reg, rxASync_reg;
	logic rxBMeta_reg, rxBSync_reg;

	// Register file and switch state
	logic [SSW_STRAP_WIDTH-1:0] strap_reg;
	ssw_port_e portSel_reg;
	logic supplyOn_reg;
	logic awHeld_reg, wHeld_reg;
	logic [3:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;

	// Decoded straps
	logic cfgStatus, cfgDefPort, cfgDefChoice, cfgSyncBlock;
	logic cfgHsSupply, cfgPermSupply, cfgExtSupply, cfgRoleDte, cfgIsolated;
	logic wakeFall, supplyNext, writeFire;
	logic [SSW_STAT_WIDTH-1:0] statusWord;

	// Read decode, shared by the read channel and nothing else but kept named
	function automatic logic [31:0] readWord(input logic [3:0] addr,
		input logic [SSW_STRAP_WIDTH-1:0] straps, input logic [SSW_STAT_WIDTH-1:0] stat);
		logic [31:0] word;
		word = 32'h0000_0000;
		case (addr)
			SSW_ADDR_STRAP: word[SSW_STRAP_WIDTH-1:0] = straps;
			SSW_ADDR_STATUS: word[SSW_STAT_WIDTH-1:0] = stat;
			SSW_ADDR_IDENT: word = SSW_IDENT_VALUE;
			default: word = 32'h0000_0000;
		endcase
		return word;
	endfunction

	// Address hit test, used by both channels
	function automatic logic addrMapped(input logic [3:0] addr);
		return (addr == SSW_ADDR_STRAP) || (addr == SSW_ADDR_STATUS) || (addr == SSW_ADDR_IDENT);
	endfunction

	// Two-stage synchronisers for every pin input, and the wake edge history;
	// serial lines reset to mark so a reset never looks like a start bit
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wakeMeta_reg <= 1'b0;
			wakeSync_reg <= 1'b0;
			syncMeta_reg <= 1'b0;
			syncSync_reg <= 1'b0;
			manualMeta_reg <= 1'b0;
			manualSync_reg <= 1'b0;
			selMeta_reg <= 1'b0;
			selSync_reg <= 1'b0;
			txMeta_reg <= SSW_LINE_IDLE;
			txSync_reg <= SSW_LINE_IDLE;
			rxAMeta_reg <= SSW_LINE_IDLE;
			rxASync_reg <= SSW_LINE_IDLE;
			rxBMeta_reg <= SSW_LINE_IDLE;
			rxBSync_reg <= SSW_LINE_IDLE;
			wakePrev_reg <= 1'b0;
		end
		else
		begin
			wakeMeta_reg <= logger_wake_request;
			wakeSync_reg <= wakeMeta_reg;
			syncMeta_reg <= sync_or_print_request;
			syncSync_reg <= syncMeta_reg;
			manualMeta_reg <= manualMode;
			manualSync_reg <= manualMeta_reg;
			selMeta_reg <= portSelectIn;
			selSync_reg <= selMeta_reg;
			txMeta_reg <= loggerTxData;
			txSync_reg <= txMeta_reg;
			rxAMeta_reg <= portARxData;
			rxASync_reg <= rxAMeta_reg;
			rxBMeta_reg <= portBRxData;
			rxBSync_reg <= rxBMeta_reg;
			wakePrev_reg <= wakeSync_reg;
		end
	end

	// Strap fields and derived terms
	assign cfgStatus = strap_reg[SSW_STRAP_STATUS_OUT];
	assign cfgDefPort = strap_reg[SSW_STRAP_DEFAULT_PORT];
	assign cfgDefChoice = strap_reg[SSW_STRAP_DEFAULT_CHOICE];
	assign cfgSyncBlock = strap_reg[SSW_STRAP_SYNC_BLOCK];
	assign cfgHsSupply = strap_reg[SSW_STRAP_HS_SUPPLY];
	assign cfgPermSupply = strap_reg[SSW_STRAP_PERM_SUPPLY];
	assign cfgExtSupply = strap_reg[SSW_STRAP_EXT_SUPPLY];
	assign cfgRoleDte = strap_reg[SSW_STRAP_ROLE_DTE];
	assign cfgIsolated = strap_reg[SSW_STRAP_ISOLATED];
	assign wakeFall = wakePrev_reg && !wakeSync_reg;

	// Port selection; a single enum bit cannot express "no port" at all
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			portSel_reg <= SSW_SEL_A;
		else if (manualSync_reg)
			portSel_reg <= selSync_reg ? SSW_SEL_B : SSW_SEL_A;
		else if (wakeFall && cfgDefPort)
			portSel_reg <= cfgDefChoice ? SSW_SEL_B : SSW_SEL_A;
		// Without the default-port strap the last port simply stays
	end

	// Status terminal drives only in auto mode with its strap fitted
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			portSelectOe <= 1'b0;
			portSelectOut <= 1'b0;
		end
		else
		begin
			portSelectOe <= cfgStatus && !manualSync_reg;
			portSelectOut <= (portSel_reg == SSW_SEL_B);
		end
	end

	// Handshake supply enable
	always_comb
	begin
		if (!cfgHsSupply || cfgIsolated)
			supplyNext = 1'b0;
		else if (cfgPermSupply)
			supplyNext = 1'b1;
		else if (cfgExtSupply)
			supplyNext = wakeSync_reg || syncSync_reg;
		else
			supplyNext = wakeSync_reg;
	end

	// Supply steered to the pair that the port role dictates
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			supplyOn_reg <= 1'b0;
			supplyDtePair <= 1'b0;
			supplyDcePair <= 1'b0;
		end
		else
		begin
			supplyOn_reg <= supplyNext;
			supplyDtePair <= supplyNext && cfgRoleDte;
			supplyDcePair <= supplyNext && !cfgRoleDte;
		end
	end

	// Data routing; the unselected port sees a steady mark so it never takes noise as data
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			portATxData <= SSW_LINE_IDLE;
			portBTxData <= SSW_LINE_IDLE;
			loggerRxData <= SSW_LINE_IDLE;
		end
		else
		begin
			if (portSel_reg == SSW_SEL_A && !(cfgSyncBlock && syncSync_reg))
				portATxData <= txSync_reg;
			else
				portATxData <= SSW_LINE_IDLE;
			portBTxData <= (portSel_reg == SSW_SEL_B) ? txSync_reg : SSW_LINE_IDLE;
			loggerRxData <= (portSel_reg == SSW_SEL_B) ? rxBSync_reg : rxASync_reg;
		end
	end

	// Write channel: address and data taken in either order, response once both are in
	assign writeFire = awHeld_reg && wHeld_reg && !s_axi_bvalid;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 4'h0;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SSW_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready) && !writeFire;
			s_axi_wready <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready) && !writeFire;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (writeFire)
			begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addrMapped(awAddr_reg) ? SSW_RESP_OKAY : SSW_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Strap register; status and identity words ignore writes
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			strap_reg <= SSW_STRAP_RESET;
		else if (writeFire && awAddr_reg == SSW_ADDR_STRAP)
		begin
			if (wStrb_reg[0])
				strap_reg[SSW_STRAP_ROLE_DTE:0] <= wData_reg[SSW_STRAP_ROLE_DTE:0];
			if (wStrb_reg[1])
				strap_reg[SSW_STRAP_ISOLATED] <= wData_reg[SSW_STRAP_ISOLATED];
		end
	end

	// Read channel answers one cycle after the address is taken
	assign statusWord = {supplyOn_reg, manualSync_reg, syncSync_reg, wakeSync_reg,
		portSel_reg == SSW_SEL_B};

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= SSW_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= readWord(s_axi_araddr, strap_reg, statusWord);
				s_axi_rresp <= addrMapped(s_axi_araddr) ? SSW_RESP_OKAY : SSW_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Checks on the switch behaviour
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	status_drive_a: assert property (
		(cfgStatus && !manualSync_reg) |=> portSelectOe && (portSelectOut == $past(portSel_reg == SSW_SEL_B)))
		else $error("status terminal not driven with port state");
	status_release_a: assert property (
		(!cfgStatus || manualSync_reg) |=> !portSelectOe)
		else $error("status terminal driven when it should be an input");
	default_port_a: assert property (
		(wakeFall && !manualSync_reg && cfgDefPort && cfgDefChoice) |=> portSel_reg == SSW_SEL_B ##1
		portSelectOut || !portSelectOe)
		else $error("default port B not taken on wake fall");
	default_portA_a: assert property (
		(wakeFall && !manualSync_reg && cfgDefPort && !cfgDefChoice) |=> portSel_reg == SSW_SEL_A)
		else $error("default port A not taken on wake fall");
	keep_port_a: assert property (
		(wakeFall && !manualSync_reg && !cfgDefPort) |=> $stable(portSel_reg))
		else $error("port changed without default strap");
	sync_block_a: assert property (
		(cfgSyncBlock && syncSync_reg) |=> portATxData == SSW_LINE_IDLE)
		else $error("data reached port A during sync transfer");
	supply_gate_a: assert property (
		(cfgHsSupply && !cfgIsolated && cfgPermSupply) [*2] |=> supplyOn_reg)
		else $error("permanent supply dropped");
	supply_ext_a: assert property (
		(cfgHsSupply && !cfgIsolated && !cfgPermSupply) |=>
		supplyOn_reg == $past(wakeSync_reg || (cfgExtSupply && syncSync_reg)))
		else $error("supply enable does not follow requests");
	supply_iso_a: assert property (
		(cfgIsolated || !cfgHsSupply) |=> !supplyDtePair && !supplyDcePair)
		else $error("supply present while disabled");
	role_pair_a: assert property (
		!(supplyDtePair && supplyDcePair) && (supplyDtePair || supplyDcePair) == supplyOn_reg)
		else $error("supply on wrong or both pairs");
	manual_sel_a: assert property (
		manualSync_reg |=> portSel_reg == ($past(selSync_reg) ? SSW_SEL_B : SSW_SEL_A))
		else $error("manual select not followed");
	// A short wake pulse may legally fall again two edges later, so only the next edge is barred
	wake_once_a: assert property (
		wakeFall |-> $fell(wakeSync_reg) ##1 !wakeFall)
		else $error("one wake fall seen twice");
	one_port_a: assert property (
		(portSel_reg == SSW_SEL_A) |=> ##1 (portBTxData == SSW_LINE_IDLE) || $past(portSel_reg) == SSW_SEL_B)
		else $error("unselected port B carries data");

	cover_default_b_c: cover property (wakeFall && cfgDefPort && cfgDefChoice ##1 portSel_reg == SSW_SEL_B);
	cover_manual_b_c: cover property (manualSync_reg && selSync_reg ##1 portSel_reg == SSW_SEL_B);
	cover_block_c: cover property (cfgSyncBlock && syncSync_reg && !txSync_reg);
	cover_supply_c: cover property (cfgExtSupply && !wakeSync_reg ##1 supplyOn_reg);

endmodule
